// >>> hw/sdes_consts.svh
// Constants for the serial to 16-bit deserializer with word alignment.
`ifndef SDES_CONSTS_SVH
`define SDES_CONSTS_SVH

// Word assembly.
`define SDES_WORD_W        16
`define SDES_CNT_W         4
`define SDES_FIRST_BIT     4'h0
`define SDES_HALF_WORD     4'h8
`define SDES_LAST_BIT      4'hf

// System clock and lock release timing.
`define SDES_SYS_PERIOD_PS 8000
`define SDES_LOCK_DELAY_NS 800
`define SDES_LOCK_CYC      ((`SDES_LOCK_DELAY_NS * 1000) / `SDES_SYS_PERIOD_PS)
`define SDES_LOCK_CNT_W    8

// Frequency detector measurement window, expected bit edges and tolerance.
`define SDES_FD_WINDOW     256
`define SDES_FD_EXPECT     32
`define SDES_FD_TOL        1
`define SDES_FD_CNT_W      16

`endif

// >>> hw/sdes_pkg.sv
// Types shared by the deserializer design.
package sdes_pkg;

   // Direction that the frequency detector drives the oscillator.
   typedef enum logic [1:0] {
      FD_NEUTRAL,
      FD_UP,
      FD_DOWN
   } sdes_fd_dir_t;

   // Lock monitor states.
   typedef enum logic [1:0] {
      LK_LOST,
      LK_WAIT,
      LK_LOCKED
   } sdes_lock_st_t;

endpackage

// >>> hw/sdes_top.sv
// Serial to 16-bit deserializer: input select, word slip, word clock, lock monitor.
//
// Functional notes
// - Word output changes only on word-clock fall.
// - Sixteen retimed bits form each parallel word.
// - Realignment completes within two word clocks.
// - Realignment drops first bit of word cycle.
// - Lock-lost goes low immediately on lock loss.
// - Lock-lost releases high about 800 ns later.
// - Lock-lost does not flag missing input signal.
// - Select low takes the main serial input.
// - Detector steers by sign, neutral within FD_TOL edges of the expected count.
// - Each bit sampled mid-period by recovered clock.
// - Long identical-bit runs keep lock and words.
`timescale 1ns/1ps
`default_nettype none
`include "sdes_consts.svh"

module sdes_top
   import sdes_pkg::*;
#(
   parameter int unsigned FD_WINDOW = `SDES_FD_WINDOW,
   parameter int unsigned FD_EXPECT = `SDES_FD_EXPECT,
   parameter int unsigned FD_TOL    = `SDES_FD_TOL
) (
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_reset,
   input  wire logic                     i_bit_clk,
   input  wire logic                     i_main_serial_in,
   input  wire logic                     i_loopback_serial_in,
   input  wire logic                     i_input_source_select,
   input  wire logic                     i_realign_pulse,
   output logic                          o_word_clk,
   output logic [`SDES_WORD_W-1:0]       o_parallel_word_out,
   output logic                          o_lock_lost_n,
   output logic                          o_vco_up,
   output logic                          o_vco_down
);

   localparam logic [`SDES_FD_CNT_W-1:0] WIN_LAST = `SDES_FD_CNT_W'(FD_WINDOW - 1);
   localparam logic [`SDES_FD_CNT_W-1:0] EXP_LO   = `SDES_FD_CNT_W'(FD_EXPECT - FD_TOL);
   localparam logic [`SDES_FD_CNT_W-1:0] EXP_HI   = `SDES_FD_CNT_W'(FD_EXPECT + FD_TOL);
   localparam logic [`SDES_LOCK_CNT_W-1:0] LOCK_LAST =
      `SDES_LOCK_CNT_W'(`SDES_LOCK_CYC - 1);

   // ------------------------------------------------------------------
   // Bit-clock domain. The recovered clock runs free from the oscillator,
   // so the system reset is carried over as a level through two flops.
   // ------------------------------------------------------------------
   logic                     rst_m_r;
   logic                     rst_b_r;
   logic                     main_m_r;
   logic                     main_s_r;
   logic                     lb_m_r;
   logic                     lb_s_r;
   logic                     sel_m_r;
   logic                     sel_s_r;
   logic                     align_m_r;
   logic                     align_s_r;
   logic                     align_d_r;
   logic                     bit_tog_r;
   logic [`SDES_CNT_W-1:0]   bit_cnt_r;
   logic [`SDES_CNT_W-1:0]   bit_cnt_nxt;
   logic [`SDES_WORD_W-1:0]  shift_r;
   logic [`SDES_WORD_W-1:0]  shift_nxt;
   logic [`SDES_WORD_W-1:0]  hold_r;
   logic [`SDES_WORD_W-1:0]  word_r;
   logic                     wclk_r;
   logic                     wclk_nxt;
   logic                     slip_pend_r;
   logic                     slip_pend_nxt;

   // Each pin is retimed on the rising edge of the recovered clock, which
   // the loop places in the middle of the bit.
   always_ff @(posedge i_bit_clk) begin
      rst_m_r   <= i_reset;
      rst_b_r   <= rst_m_r;
      main_m_r  <= i_main_serial_in;
      main_s_r  <= main_m_r;
      lb_m_r    <= i_loopback_serial_in;
      lb_s_r    <= lb_m_r;
      sel_m_r   <= i_input_source_select;
      sel_s_r   <= sel_m_r;
      align_m_r <= i_realign_pulse;
      align_s_r <= align_m_r;
      align_d_r <= align_s_r;
   end

   wire serial_bit   = sel_s_r ? lb_s_r : main_s_r;
   // The pulse spans at least four bits, so the two-flop sampler sees it.
   wire realign_rise = align_s_r & ~align_d_r;
   wire slip_take    = slip_pend_r && (bit_cnt_r == `SDES_FIRST_BIT);
   wire word_last    = !slip_take && (bit_cnt_r == `SDES_LAST_BIT);
   wire word_fall    = !slip_take && (bit_cnt_r == (`SDES_HALF_WORD - 4'h1));

   // A dropped bit neither enters the word nor advances the count, so the
   // word-clock high phase stretches by exactly one bit.
   assign bit_cnt_nxt   = slip_take ? bit_cnt_r : bit_cnt_r + 4'h1;
   assign shift_nxt     = slip_take ? shift_r
                                    : {shift_r[`SDES_WORD_W-2:0], serial_bit};
   assign wclk_nxt      = (bit_cnt_nxt < `SDES_HALF_WORD);
   // A new request wins over the clearing of an old one.
   assign slip_pend_nxt = realign_rise | (slip_pend_r & ~slip_take);

   always_ff @(posedge i_bit_clk) begin
      if (rst_b_r) begin
         bit_cnt_r   <= `SDES_FIRST_BIT;
         shift_r     <= '0;
         hold_r      <= '0;
         word_r      <= '0;
         wclk_r      <= 1'b1;
         slip_pend_r <= 1'b0;
         bit_tog_r   <= 1'b0;
      end else begin
         bit_cnt_r   <= bit_cnt_nxt;
         shift_r     <= shift_nxt;
         wclk_r      <= wclk_nxt;
         slip_pend_r <= slip_pend_nxt;
         bit_tog_r   <= ~bit_tog_r;
         if (word_last) begin
            hold_r <= shift_nxt;
         end
         if (word_fall) begin
            word_r <= hold_r;
         end
      end
   end

   assign o_word_clk          = wclk_r;
   assign o_parallel_word_out = word_r;

   // ------------------------------------------------------------------
   // System-clock domain: frequency detector and lock monitor. Bit-clock
   // activity crosses as a toggle; one change is one recovered clock.
   // The detector counts clock cycles, not data transitions, so long runs
   // of identical bits do not disturb it. It cannot see a missing input
   // signal, because the oscillator keeps running without data.
   // ------------------------------------------------------------------
   logic                          tog_m_r;
   logic                          tog_s_r;
   logic                          tog_d_r;
   logic [`SDES_FD_CNT_W-1:0]     win_cnt_r;
   logic [`SDES_FD_CNT_W-1:0]     edge_cnt_r;
   logic [`SDES_FD_CNT_W-1:0]     edge_cnt_nxt;
   sdes_fd_dir_t                  fd_dir_r;
   sdes_fd_dir_t                  fd_dir_nxt;
   sdes_lock_st_t                 lk_st_r;
   sdes_lock_st_t                 lk_st_nxt;
   logic [`SDES_LOCK_CNT_W-1:0]   dly_cnt_r;
   logic                          lock_n_r;

   always_ff @(posedge i_sys_clk) begin
      tog_m_r <= bit_tog_r;
      tog_s_r <= tog_m_r;
      tog_d_r <= tog_s_r;
   end

   // Counting clock edges rather than data edges keeps long identical runs harmless.
   wire bit_edge = tog_s_r ^ tog_d_r;
   wire win_end  = (win_cnt_r == WIN_LAST);
   assign edge_cnt_nxt = edge_cnt_r + {{(`SDES_FD_CNT_W-1){1'b0}}, bit_edge};

   // Too few edges means the oscillator is slow and is pushed up.
   assign fd_dir_nxt = (edge_cnt_nxt < EXP_LO) ? FD_UP   :
                       (edge_cnt_nxt > EXP_HI) ? FD_DOWN : FD_NEUTRAL;
   wire freq_ok = (fd_dir_nxt == FD_NEUTRAL);

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         win_cnt_r  <= '0;
         edge_cnt_r <= '0;
         fd_dir_r   <= FD_NEUTRAL;
      end else begin
         win_cnt_r  <= win_end ? '0 : win_cnt_r + 16'h0001;
         edge_cnt_r <= win_end ? '0 : edge_cnt_nxt;
         if (win_end) begin
            fd_dir_r <= fd_dir_nxt;
         end
      end
   end

   assign o_vco_up   = (fd_dir_r == FD_UP);
   assign o_vco_down = (fd_dir_r == FD_DOWN);

   always_comb begin
      lk_st_nxt = lk_st_r;
      unique case (lk_st_r)
         LK_LOST: begin
            if (win_end && freq_ok) begin
               lk_st_nxt = LK_WAIT;
            end
         end
         LK_WAIT: begin
            if (win_end && !freq_ok) begin
               lk_st_nxt = LK_LOST;
            end else if (dly_cnt_r == LOCK_LAST) begin
               lk_st_nxt = LK_LOCKED;
            end
         end
         LK_LOCKED: begin
            if (win_end && !freq_ok) begin
               lk_st_nxt = LK_LOST;
            end
         end
         default: begin
            lk_st_nxt = LK_LOST;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         lk_st_r   <= LK_LOST;
         dly_cnt_r <= '0;
         lock_n_r  <= 1'b0;
      end else begin
         lk_st_r   <= lk_st_nxt;
         dly_cnt_r <= (lk_st_r == LK_WAIT) ? dly_cnt_r + 8'h01 : '0;
         lock_n_r  <= (lk_st_nxt == LK_LOCKED);
      end
   end

   assign o_lock_lost_n = lock_n_r;

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------
   a_word_on_fall: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      (word_r != $past(word_r)) |-> $fell(wclk_r))
      else $error("Parallel word changed away from a word clock fall.");

   a_word_bit_order: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      word_last |=> (hold_r == {$past(shift_r[`SDES_WORD_W-2:0]), $past(serial_bit)}))
      else $error("Assembled word does not hold the last sixteen bits in order.");

   a_word_low_half: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      $fell(wclk_r) |-> !wclk_r [*8] ##1 wclk_r)
      else $error("Word clock low phase is not eight bits.");

   a_word_high_half: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      ($rose(wclk_r) && !slip_pend_r && !realign_rise) |-> wclk_r [*8])
      else $error("Word clock high phase is shorter than eight bits.");

   a_slip_bound: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      realign_rise |-> ##[0:31] slip_take)
      else $error("Realignment not done within two word clocks.");

   a_slip_drop: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      slip_take |=> (shift_r == $past(shift_r)) && (bit_cnt_r == `SDES_FIRST_BIT)
                    && !slip_pend_r ##1 (bit_cnt_r == 4'h1))
      else $error("Realignment did not drop exactly one bit.");

   a_slip_stretch: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      slip_take |=> wclk_r [*8] ##1 !wclk_r)
      else $error("Word clock high phase not stretched by one bit on a slip.");

   a_src_main: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      (!sel_s_r && !slip_take) |=> (shift_r[0] == $past(main_s_r)))
      else $error("Main input not taken while select is low.");

   a_src_loop: assert property (
      @(posedge i_bit_clk) disable iff (rst_b_r)
      (sel_s_r && !slip_take) |=> (shift_r[0] == $past(lb_s_r)))
      else $error("Loopback input not taken while select is high.");

   a_lock_drop: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (win_end && !freq_ok) |=> !o_lock_lost_n && (lk_st_r == LK_LOST))
      else $error("Lock-lost not asserted at once on frequency error.");

   a_lock_release: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      $rose(o_lock_lost_n) |-> ($past(dly_cnt_r) == LOCK_LAST)
                               && ($past(lk_st_r) == LK_WAIT))
      else $error("Lock-lost released without the full lock delay.");

   a_fd_neutral: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (win_end && freq_ok) |=> (!o_vco_up && !o_vco_down) throughout (!win_end [*1]))
      else $error("Frequency detector drives the oscillator at zero difference.");

   a_fd_steer_up: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (win_end && (edge_cnt_nxt < EXP_LO)) |=> o_vco_up && !o_vco_down)
      else $error("Frequency detector did not push a slow oscillator up.");

   a_fd_steer_down: assert property (
      @(posedge i_sys_clk) disable iff (i_reset)
      (win_end && (edge_cnt_nxt > EXP_HI)) |=> o_vco_down && !o_vco_up)
      else $error("Frequency detector did not pull a fast oscillator down.");

endmodule // sdes_top

`default_nettype wire

// >>> dv/sdes_framer_model.sv
// Downstream framer model that takes each parallel word on the rising word clock.
`timescale 1ns/1ps
`default_nettype none
`include "sdes_consts.svh"
module sdes_framer_model (
   input  wire logic                    i_word_clk,
   input  wire logic                    i_en,
   input  wire logic [`SDES_WORD_W-1:0] i_word,
   output var  logic [`SDES_WORD_W-1:0] o_word,
   output var  int                      o_glitch
);
   initial o_glitch = 0;
   always @(posedge i_word_clk) o_word <= i_word;
   // A change seen while the word clock is still high would race the framer's sample.
   always @(i_word) begin
      #1;
      if (i_en && i_word_clk === 1'b1) o_glitch <= o_glitch + 1;
   end
endmodule // sdes_framer_model
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the deserializer top with a reference bit stream model.
`timescale 1ns/1ps
`default_nettype none
`include "sdes_consts.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
   $display("wrong value %s exp %h got %h", n, e, g); bad_count++; end end
module tb;
   logic                    clk, bclk, rst, m_in, l_in, src, rl, sel, mode, chk_en;
   logic                    wclk, lock_n, up, dn;
   logic [`SDES_WORD_W-1:0] word, pw;
   logic [31:0]             xs;
   real                     bper;
   bit                      bits[$];
   bit                      synced;
   int                      bad_count, n_compared, pos, skip, slip_left, slips;
   int                      rl_cnt, glitch, n, lost;

   sdes_top DUT (.i_sys_clk(clk), .i_reset(rst), .i_bit_clk(bclk), .i_main_serial_in(m_in),
      .i_loopback_serial_in(l_in), .i_input_source_select(src), .i_realign_pulse(rl),
      .o_word_clk(wclk), .o_parallel_word_out(word), .o_lock_lost_n(lock_n),
      .o_vco_up(up), .o_vco_down(dn));
   sdes_framer_model FRM (.i_word_clk(wclk), .i_en(chk_en), .i_word(word), .o_word(pw),
      .o_glitch(glitch));

   initial forever #4 clk = ~clk;
   initial begin
      #3;
      forever #(bper / 2.0) bclk = ~bclk;
   end

   function automatic logic [31:0] xsh(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   function automatic logic [15:0] expw(input int k);
      expw = '0;
      for (int i = 0; i < 16; i++) expw = {expw[14:0], bits[k + i]};
   endfunction

   function automatic logic pick(input int w);
      return (w == 0) ? lock_n : ((w == 1) ? up : dn);
   endfunction

   task automatic conclude();
      if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic wait_for(input int w, input int lim, output int c);
      c = 0;
      while (pick(w) !== 1'b1) begin
         @(negedge clk);
         c++;
         if (c > lim) begin
            bad_count++;
            conclude();
         end
      end
   endtask

   task automatic words(input int k);
      repeat (16 * k) @(negedge bclk);
   endtask

   // Only the selected line carries the reference stream; the other carries noise.
   always @(negedge bclk) begin
      xs = xsh(xs);
      src <= sel;
      m_in <= sel ? xs[3] : (mode ? 1'b0 : xs[0]);
      l_in <= sel ? (mode ? 1'b0 : xs[0]) : xs[3];
      bits.push_back(mode ? 1'b0 : xs[0]);
      rl <= (rl_cnt != 0);
      if (rl_cnt != 0) rl_cnt--;
   end

   always @(negedge clk) if (mode && lock_n !== 1'b1) lost++;

   always @(posedge wclk) if (chk_en) begin
      #1;
      if (skip > 0) skip--;
      else if (!synced) begin
         for (int k = bits.size() - 16; k > bits.size() - 120 && k >= 0; k--)
            if (!synced && expw(k) === pw) begin
               synced = 1;
               pos = k + 16;
            end
         `CHK("alignment", 1'b1, synced)
      end else begin
         if (slip_left > 0) begin
            slip_left--;
            if (expw(pos + 1) === pw) begin
               pos++;
               slip_left = 0;
               slips++;
            end else if (slip_left == 0) `CHK("slip deadline", 1'b0, 1'b1)
         end
         `CHK("word", expw(pos), pw)
         pos += 16;
      end
   end

   initial begin
      clk = 0; bclk = 0; rst = 1; m_in = 0; l_in = 0; src = 0; rl = 0; sel = 0; mode = 0;
      chk_en = 0; xs = 32'h29de2f85; bper = 64.0; bad_count = 0; n_compared = 0; skip = 3;
      slip_left = 0; slips = 0; synced = 0; rl_cnt = 0; lost = 0; pos = 0;
      // The link side needs three of its own clocks inside reset, hence the longer hold.
      repeat (40) @(negedge clk);
      rst = 0;
      wait_for(0, 700, n);
      `CHK("lock delay", 1'b1, n >= 356 && n <= 630)
      `CHK("steer neutral", 2'b00, {up, dn})
      chk_en = 1;
      words(30);
      sel = 1; synced = 0; skip = 3;
      words(30);
      sel = 0; synced = 0; skip = 3;
      words(30);
      repeat (2) begin
         slip_left = 4;
         rl_cnt = 5;
         words(8);
      end
      mode = 1;
      words(130);
      mode = 0;
      `CHK("run lock held", 0, lost)
      bper = 80.0;
      wait_for(1, 1200, n);
      @(negedge clk);
      `CHK("lock lost now", 1'b0, lock_n)
      `CHK("steer up", 2'b10, {up, dn})
      bper = 48.0;
      wait_for(2, 1200, n);
      `CHK("steer down", 2'b01, {up, dn})
      bper = 64.0;
      wait_for(0, 1200, n);
      `CHK("steer neutral", 2'b00, {up, dn})
      words(4);
      `CHK("word stable high", 0, glitch)
      `CHK("slip count", 2, slips)
      `CHK("words flowing", 1'b1, synced)
      conclude();
   end
endmodule // tb
`default_nettype wire
